// *** pkg/gpt_pkg.sv ***
/*
  Package for the dual module timer unit: register indices, control field
  positions, reset values and prescaler constants.
  Assumes a 16-bit word register port driven by a simple strobe master.
*/
package gpt_pkg;
	localparam int TW = 16;
	localparam int AW = 4;
	// --------------------------------------------------------------
	// Register indices
	// --------------------------------------------------------------
	localparam logic [3:0] A_AUXL_CTL = 4'h0;
	localparam logic [3:0] A_CORE1_CTL = 4'h1;
	localparam logic [3:0] A_AUXH_CTL = 4'h2;
	localparam logic [3:0] A_AUX2_CTL = 4'h3;
	localparam logic [3:0] A_CORE2_CTL = 4'h4;
	localparam logic [3:0] A_AUXL_CNT = 4'h5;
	localparam logic [3:0] A_CORE1_CNT = 4'h6;
	localparam logic [3:0] A_AUXH_CNT = 4'h7;
	localparam logic [3:0] A_AUX2_CNT = 4'h8;
	localparam logic [3:0] A_CORE2_CNT = 4'h9;
	localparam logic [3:0] A_CAPTURE_RELOAD_REGISTER = 4'hA;
	localparam logic [3:0] A_IRQ = 4'hB;
	localparam logic [3:0] A_PRIO = 4'hC;
	// --------------------------------------------------------------
	// Control field positions
	// --------------------------------------------------------------
	localparam int F_PRE = 0;   // [2:0] prescale exponent
	localparam int F_MODE = 3;  // [5:3] mode
	localparam int F_RUN = 6;
	localparam int F_DOWN = 7;
	localparam int F_EUD = 8;   // direction pin enable
	localparam int F_IEDGE = 9; // [10:9] input edge select
	localparam int F_OE = 11;   // toggle pin output enable
	localparam int F_RTRIG = 12; // [13:12] reload on latch rise/fall
	localparam int F_CLR = 14;  // clear aux after capture
	localparam int F_IE = 15;
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// Modes: timer, gated low, gated high, counter, reload, capture
	localparam logic [2:0] M_TIMER = 3'h0;
	localparam logic [2:0] M_GATE_LO = 3'h2;
	localparam logic [2:0] M_GATE_HI = 3'h3;
	localparam logic [2:0] M_COUNT = 3'h1;
	localparam logic [2:0] M_RELOAD = 3'h4;
	localparam logic [2:0] M_CAPTURE = 3'h5;
	// --------------------------------------------------------------
	// Timing: base divider at the finest resolution
	// --------------------------------------------------------------
	// Finest ticks are counted in CPU clocks at the reference rate, not in ns
	localparam int REF_MHZ = 20;
	localparam int RES1_NS = 400;
	localparam int RES2_NS = 200;
	localparam int DIV1 = (RES1_NS * REF_MHZ) / 1000;
	localparam int DIV2 = (RES2_NS * REF_MHZ) / 1000;
endpackage

// *** core/gpt_unit.sv ***
/*
  Dual module general purpose timer unit: five 16-bit up/down timers.
  Assumes pins synchronous to clk and a one-cycle strobe register master.
*/
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module gpt_unit #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [gpt_pkg::AW-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [4:0] timer_gate_or_count_pin,
	input wire logic [4:0] external_direction_pin,
	input wire logic capture_trigger_pin,
	output logic first_core_toggle_pin,
	output logic first_aux_high_toggle_pin,
	output logic second_core_toggle_pin,
	output logic capture_compare_unit_clk,
	output logic [5:0] irq_req
);
	import gpt_pkg::*;

	initial begin
		if (W != TW) $error("gpt_unit supports only 16-bit timers");
	end

	// Timer index: 0 aux low, 1 core1, 2 aux high, 3 aux2, 4 core2
	logic [15:0] ctl_ff [5];
	logic [W-1:0] cnt_ff [5];
	logic [W-1:0] capture_reload_register_ff;
	logic [5:0] irq_ff;
	logic [5:0] ie_ff;
	logic [23:0] prio_ff;
	logic [2:0] latch_ff;      // core1, auxh, core2
	logic [4:0] pin_q_ff;
	logic cap_q_ff;
	logic [2:0] latch_q_ff;
	logic [15:0] rdata_ff;
	logic [2:0] base1_ff;
	logic [1:0] base2_ff;
	logic [8:0] pre_ff;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
		edge_hit = (sel[0] & now & ~was) | (sel[1] & ~now & was);
	endfunction

	function automatic logic pre_tick(input logic [2:0] e, input logic [8:0] p, input logic b);
		// Prescale 2^e of the base tick
		pre_tick = b && ((p & ((9'h001 << e) - 9'h001)) == 9'h000);
	endfunction

	// ----------------------------------------------------------------
	// Prescaler base
	// ----------------------------------------------------------------
	logic base1;
	logic base2;
	assign base1 = (base1_ff == 3'(DIV1 - 1));
	assign base2 = (base2_ff == 2'(DIV2 - 1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			base1_ff <= 3'h0;
			base2_ff <= 2'h0;
			pre_ff <= 9'h000;
		end else begin
			base1_ff <= base1 ? 3'h0 : base1_ff + 3'h1;
			base2_ff <= base2 ? 2'h0 : base2_ff + 2'h1;
			if (base1) pre_ff <= pre_ff + 9'h001;
		end
	end

	// ----------------------------------------------------------------
	// Pin and latch history for edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_q_ff <= 5'h00;
			cap_q_ff <= 1'b0;
			latch_q_ff <= 3'h0;
		end else begin
			pin_q_ff <= timer_gate_or_count_pin;
			cap_q_ff <= capture_trigger_pin;
			latch_q_ff <= latch_ff;
		end
	end

	// ----------------------------------------------------------------
	// Per-timer count enables
	// ----------------------------------------------------------------
	logic [4:0] step;
	logic [4:0] wrap;
	logic [4:0] down;
	logic [2:0] lat_rise;
	logic [2:0] lat_fall;
	assign lat_rise = latch_ff & ~latch_q_ff;
	assign lat_fall = ~latch_ff & latch_q_ff;

	always_comb begin
		logic [2:0] m;
		logic pin;
		logic pe;
		logic tick;
		logic chain;
		m = 3'h0;
		pin = 1'b0;
		pe = 1'b0;
		tick = 1'b0;
		chain = 1'b0;
		for (int i = 0; i < 5; i++) begin
			m = ctl_ff[i][F_MODE+:3];
			pin = timer_gate_or_count_pin[i];
			pe = edge_hit(ctl_ff[i][F_IEDGE+:2], pin, pin_q_ff[i]);
			tick = (i < 3) ? pre_tick(ctl_ff[i][F_PRE+:3], pre_ff, base1)
				: pre_tick(ctl_ff[i][F_PRE+:3], pre_ff, base2);
			// Aux timers in counter mode may count core latch edges
			if (i == 0 || i == 2)
				chain = edge_hit(ctl_ff[i][F_IEDGE+:2], latch_ff[0], latch_q_ff[0]);
			else if (i == 3)
				chain = edge_hit(ctl_ff[i][F_IEDGE+:2], latch_ff[2], latch_q_ff[2]);
			else
				chain = 1'b0;
			step[i] = 1'b0;
			if (ctl_ff[i][F_RUN]) begin
				unique case (m)
					M_TIMER: step[i] = tick;
					M_GATE_LO: step[i] = tick & ~pin;
					M_GATE_HI: step[i] = tick & pin;
					M_COUNT: step[i] = pe | chain;
					default: step[i] = 1'b0;
				endcase
			end
			// Direction pin, when enabled and high, inverts the software direction
			down[i] = ctl_ff[i][F_EUD] ? (ctl_ff[i][F_DOWN] ^ external_direction_pin[i])
				: ctl_ff[i][F_DOWN];
			wrap[i] = step[i] && (down[i] ? (cnt_ff[i] == '0) : (cnt_ff[i] == '1));
		end
	end

	// Capture and reload events for the first module
	logic [1:0] aux_cap;
	logic [1:0] aux_rel;
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			logic [15:0] c;
			logic pe;
			c = ctl_ff[2*k];
			pe = edge_hit(c[F_IEDGE+:2], timer_gate_or_count_pin[2*k], pin_q_ff[2*k]);
			aux_cap[k] = c[F_MODE+:3] == M_CAPTURE && pe;
			// Pin edge or chosen latch transition; opposite picks give PWM
			aux_rel[k] = c[F_MODE+:3] == M_RELOAD &&
				(pe || (c[F_RTRIG] && lat_rise[0]) || (c[F_RTRIG+1] && lat_fall[0]));
		end
	end

	logic cap2;
	assign cap2 = edge_hit(ctl_ff[4][F_IEDGE+:2], capture_trigger_pin, cap_q_ff);

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	logic [3:0] cnt_addr [5];
	assign cnt_addr[0] = A_AUXL_CNT;
	assign cnt_addr[1] = A_CORE1_CNT;
	assign cnt_addr[2] = A_AUXH_CNT;
	assign cnt_addr[3] = A_AUX2_CNT;
	assign cnt_addr[4] = A_CORE2_CNT;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 5; i++) cnt_ff[i] <= CNT_RST;
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (wr && addr == cnt_addr[i])
					cnt_ff[i] <= wdata;
				else if (i == 1 && aux_rel[0])
					cnt_ff[1] <= cnt_ff[0];
				else if (i == 1 && aux_rel[1])
					cnt_ff[1] <= cnt_ff[2];
				else if (i == 0 && aux_cap[0])
					cnt_ff[0] <= cnt_ff[1];
				else if (i == 2 && aux_cap[1])
					cnt_ff[2] <= cnt_ff[1];
				else if (i == 4 && wrap[4])
					cnt_ff[4] <= capture_reload_register_ff;
				else if (i == 3 && cap2 && ctl_ff[4][F_CLR])
					cnt_ff[3] <= '0;
				else if (step[i])
					cnt_ff[i] <= down[i] ? cnt_ff[i] - 16'h0001 : cnt_ff[i] + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			capture_reload_register_ff <= CNT_RST;
		else if (cap2)
			capture_reload_register_ff <= cnt_ff[3];
		else if (wr && addr == A_CAPTURE_RELOAD_REGISTER)
			capture_reload_register_ff <= wdata;
	end

	// ----------------------------------------------------------------
	// Toggle latches
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_ff <= 3'h0;
		end else begin
			latch_ff[0] <= latch_ff[0] ^ wrap[1];
			latch_ff[1] <= latch_ff[1] ^ wrap[2];
			latch_ff[2] <= latch_ff[2] ^ wrap[4];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			first_core_toggle_pin <= 1'b0;
			first_aux_high_toggle_pin <= 1'b0;
			second_core_toggle_pin <= 1'b0;
			capture_compare_unit_clk <= 1'b0;
		end else begin
			first_core_toggle_pin <= ctl_ff[1][F_OE] & latch_ff[0];
			first_aux_high_toggle_pin <= ctl_ff[2][F_OE] & latch_ff[1];
			second_core_toggle_pin <= ctl_ff[4][F_OE] & latch_ff[2];
			capture_compare_unit_clk <= wrap[4];
		end
	end

	// ----------------------------------------------------------------
	// Control registers and request flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 5; i++) ctl_ff[i] <= CTL_RST;
			prio_ff <= 24'h00_0000;
		end else begin
			for (int i = 0; i < 5; i++)
				if (wr && addr == 4'(i)) ctl_ff[i] <= wdata;
			if (wr && addr == A_PRIO) prio_ff[15:0] <= wdata;
			if (wr && addr == A_PRIO + 4'h1) prio_ff[23:16] <= wdata[7:0];
		end
	end

	always_comb begin
		for (int i = 0; i < 5; i++) ie_ff[i] = ctl_ff[i][F_IE];
		ie_ff[5] = ctl_ff[3][F_IE];
	end

	logic [5:0] ev;
	assign ev = {cap2, wrap};

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			irq_ff <= 6'h00;
		else
			irq_ff <= (irq_ff & ~((wr && addr == A_IRQ) ? wdata[5:0] : 6'h00)) | ev;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			irq_req <= 6'h00;
		else
			irq_req <= ((irq_ff & ~((wr && addr == A_IRQ) ? wdata[5:0] : 6'h00)) | ev) & ie_ff;
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
		end else if (rd) begin
			unique case (addr)
				A_AUXL_CTL, A_CORE1_CTL, A_AUXH_CTL, A_AUX2_CTL, A_CORE2_CTL:
					rdata_ff <= ctl_ff[addr[2:0]];
				A_AUXL_CNT: rdata_ff <= cnt_ff[0];
				A_CORE1_CNT: rdata_ff <= cnt_ff[1];
				A_AUXH_CNT: rdata_ff <= cnt_ff[2];
				A_AUX2_CNT: rdata_ff <= cnt_ff[3];
				A_CORE2_CNT: rdata_ff <= cnt_ff[4];
				A_CAPTURE_RELOAD_REGISTER: rdata_ff <= capture_reload_register_ff;
				A_IRQ: rdata_ff <= {7'h00, latch_ff, irq_ff};
				A_PRIO: rdata_ff <= prio_ff[15:0];
				4'hD: rdata_ff <= {8'h00, prio_ff[23:16]};
				default: rdata_ff <= 16'h0000;
			endcase
		end else begin
			rdata_ff <= 16'h0000;
		end
	end
	assign rdata = rdata_ff;
endmodule
`default_nettype wire

// *** tb/gpt_unit_assertions.sv ***
/*
  Port checker for gpt_unit: read port, wrap pulse, reset and request flags.
  Assumes a bind onto gpt_unit, one clock clk and reset rst_b.
*/
`timescale 1ns/10ps
`default_nettype none
module gpt_unit_chk
	import gpt_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [gpt_pkg::AW-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic first_core_toggle_pin,
	input wire logic first_aux_high_toggle_pin,
	input wire logic second_core_toggle_pin,
	input wire logic capture_compare_unit_clk,
	input wire logic [5:0] irq_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// --------------------------------------------------------------
	// Port relations
	// --------------------------------------------------------------
	a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data without a read");
	a_unmapped_zero: assert property (rd && addr > 4'hD |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_ctl_readback: assert property ((wr && addr <= A_CORE2_CTL) ##1
		(rd && addr == $past(addr)) |=> rdata == $past(wdata, 2))
		else $error("control read back differs");
	// A stopped or slow timer may have moved by one tick at most
	a_cnt_write: assert property ((wr && addr inside {[A_AUXL_CNT:A_CORE2_CNT]}) ##1
		(rd && addr == $past(addr)) |=> 16'(rdata - $past(wdata, 2) + 16'h0001) <= 16'h0002)
		else $error("count write lost");
	a_ccu_pulse: assert property (capture_compare_unit_clk |=> !capture_compare_unit_clk)
		else $error("wrap pulse too long");
	a_irq_hold: assert property (|($past(irq_req) & ~irq_req) |-> $past(wr))
		else $error("request dropped without write");
	a_reset_irq: assert property ($rose(rst_b) |-> (irq_req == 6'h00) [*2])
		else $error("request after reset");
	a_reset_pins: assert property ($rose(rst_b) |-> !first_core_toggle_pin &&
		!first_aux_high_toggle_pin && !second_core_toggle_pin && !capture_compare_unit_clk)
		else $error("pin active after reset");
	c_wrap: cover property (capture_compare_unit_clk);
	c_irq: cover property (irq_req != 6'h00);
	c_latch: cover property ($rose(first_core_toggle_pin));
endmodule
bind gpt_unit gpt_unit_chk #(.W(W)) chk (.clk(clk), .rst_b(rst_b), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.first_core_toggle_pin(first_core_toggle_pin),
	.first_aux_high_toggle_pin(first_aux_high_toggle_pin),
	.second_core_toggle_pin(second_core_toggle_pin),
	.capture_compare_unit_clk(capture_compare_unit_clk), .irq_req(irq_req));
`default_nettype wire

// *** tb/event_src.sv ***
/*
  External event and gate source for the timer input pins.
  Assumes the bench sets the half period, the toggling mask and static levels.
*/
`timescale 1ns/10ps
`default_nettype none
module event_src (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] half,
	input wire logic [4:0] run_mask,
	input wire logic [4:0] lvl,
	output logic [4:0] pins
);
	logic [7:0] cnt_ff;
	logic tog_ff;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 8'h00;
			tog_ff <= 1'b0;
		end else if (cnt_ff >= half) begin
			cnt_ff <= 8'h00;
			tog_ff <= ~tog_ff;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
	// Unmasked pins hold a gate or trigger level
	assign pins = (run_mask & {5{tog_ff}}) | (~run_mask & lvl);
endmodule
`default_nettype wire

// *** tb/tb_gpt_unit.sv ***
/*
  Self-checking bench for gpt_unit: rates, modes, wraps, capture, reload.
  Assumes event_src on the timer pins and the checker bound to gpt_unit.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_gpt_unit;
	import gpt_pkg::*;
	localparam logic [15:0] RUN = 16'(1) << F_RUN;
	localparam logic [15:0] RISE = 16'(1) << F_IEDGE;
	logic clk, rst_b, wr, rd, cap;
	logic [3:0] addr;
	logic [15:0] wdata, got, exp, rdata;
	logic [4:0] dir, mask, lvl, pins;
	logic [7:0] half;
	logic p1, p2, p3, ccu;
	logic [5:0] irq;
	int err_total, comparisons, seed, cyc;
	wire logic [2:0] obs = {p3, ccu, p1};
	gpt_unit #(.W(16)) uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .timer_gate_or_count_pin(pins), .external_direction_pin(dir),
		.capture_trigger_pin(cap), .first_core_toggle_pin(p1), .first_aux_high_toggle_pin(p2),
		.second_core_toggle_pin(p3), .capture_compare_unit_clk(ccu), .irq_req(irq));
	event_src src (.clk(clk), .rst_b(rst_b), .half(half), .run_mask(mask), .lvl(lvl),
		.pins(pins));
	task automatic give_verdict();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Write then read back to back, exercising the zero-gap bus case
	task automatic wrd(input logic [3:0] a, input logic [15:0] d);
		wreg(a, d);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
	endtask
	task automatic wait_obs(input int b);
		for (int i = 0; i < 60; i++) begin
			if (obs[b] === 1'b1) return;
			@(posedge clk);
			#1;
		end
		err_total++;
		give_verdict();
	endtask
	// Ticks over a random span; one tick of slack for prescaler phase
	task automatic run_chk(input int t, input logic [15:0] c, s, input int tp, input bit dn);
		cyc = 60 + $unsigned($random(seed)) % 120;
		wrd(4'(5 + t), s);
		`CHK("start", s, got)
		wreg(4'(t), c);
		repeat (cyc - 2) @(posedge clk);
		wreg(4'(t), 16'h0000);
		rreg(4'(5 + t));
		exp = dn ? s - 16'(cyc / tp) : s + 16'(cyc / tp);
		`CHK("count", 1'b1, 16'(got - exp + 16'h0001) <= 16'h0002)
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_b, wr, rd, cap, addr, wdata, dir, mask, lvl} = '0;
		half = 8'h03;
		seed = 37;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		for (int a = 0; a < 16; a++) begin
			rreg(4'(a));
			`CHK("reset value", 16'h0000, got)
		end
		for (int t = 0; t < 5; t++) begin
			exp = 16'($random(seed));
			exp[5:3] = 3'($unsigned($random(seed)) % 6);
			// Stopped, so no stray wrap sets a latch or flag for later scenarios
			exp[F_RUN] = 1'b0;
			wrd(4'(t), exp);
			`CHK("control", exp, got)
			wreg(4'(t), 16'h0000);
		end
		for (int p = 0; p < 3; p++) run_chk(1, RUN | 16'(p), 16'h0000, 8 << p, 0);
		run_chk(4, RUN, 16'h0000, 4, 0);
		run_chk(0, RUN, 16'h0000, 8, 0);
		run_chk(3, RUN | 16'(1) << F_DOWN, 16'h0100, 4, 1);
		dir <= 5'b00010;
		run_chk(1, RUN | 16'(1) << F_EUD, 16'h0100, 8, 1);
		run_chk(2, RUN | 16'(M_GATE_HI) << F_MODE, 16'h0005, 1 << 20, 0);
		lvl <= 5'b00100;
		run_chk(2, RUN | 16'(M_GATE_HI) << F_MODE, 16'h0005, 8, 0);
		mask <= 5'b00001;
		run_chk(0, RUN | RISE | 16'(M_COUNT) << F_MODE, 16'h0000, 8, 0);
		mask <= 5'b00000;
		lvl <= 5'b00000;
		wreg(A_CORE1_CNT, 16'hFFFE);
		wreg(A_CORE1_CTL, RUN | 16'(1) << F_OE | 16'(1) << F_IE);
		wait_obs(0);
		`CHK("first core pin", 1'b1, p1)
		repeat (2) @(posedge clk);
		`CHK("core irq", 1'b1, irq[1])
		wreg(A_IRQ, 16'h003F);
		rreg(A_IRQ);
		`CHK("irq cleared", 6'h00, irq)
		`CHK("irq flags", 6'h00, got[5:0])
		wreg(A_CORE1_CTL, 16'h0000);
		wreg(A_CORE2_CNT, 16'hFFFE);
		wreg(A_CORE2_CTL, RUN | 16'(1) << F_OE);
		wait_obs(1);
		repeat (2) @(posedge clk);
		#1;
		`CHK("second core pin", 1'b1, p3)
		wreg(A_CORE2_CTL, 16'h0000);
		rreg(A_CORE2_CNT);
		`CHK("reload from zero", 1'b1, got < 16'h0010)
		wreg(A_CORE1_CNT, 16'h1234);
		wreg(A_AUXL_CTL, RISE | 16'(M_CAPTURE) << F_MODE);
		lvl <= 5'b00001;
		repeat (4) @(posedge clk);
		rreg(A_AUXL_CNT);
		`CHK("capture", 16'h1234, got)
		wreg(A_AUXH_CNT, 16'h0777);
		wreg(A_AUXH_CTL, RISE | 16'(M_RELOAD) << F_MODE);
		lvl <= 5'b00101;
		repeat (4) @(posedge clk);
		rreg(A_CORE1_CNT);
		`CHK("reload", 16'h0777, got)
		wreg(A_AUX2_CNT, 16'h0ABC);
		wreg(A_CORE2_CTL, RISE | 16'(1) << F_CLR);
		cap <= 1'b1;
		repeat (3) @(posedge clk);
		rreg(A_CAPTURE_RELOAD_REGISTER);
		`CHK("capture register", 16'h0ABC, got)
		rreg(A_AUX2_CNT);
		`CHK("aux cleared", 16'h0000, got)
		give_verdict();
	end
endmodule
`default_nettype wire
